// ### design/gic_pkg.sv
/*
 * gic_pkg: constants and types for the global interrupt aggregator and
 * general purpose 16-bit timer.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package gic_pkg;

   localparam int NUM_CH = 8;
   localparam int ADDR_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFF_PENDING = 8'h00;
   localparam logic [7:0] OFF_SRC_LOW = 8'h04;
   localparam logic [7:0] OFF_SRC_MID = 8'h08;
   localparam logic [7:0] OFF_SRC_HIGH = 8'h0C;
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam logic [7:0] OFF_RSVD = 8'h14;
   localparam logic [7:0] OFF_LIM_LOW = 8'h18;
   localparam logic [7:0] OFF_LIM_HIGH = 8'h1C;
   localparam logic [7:0] OFF_INT_EN = 8'h20;
   localparam logic [7:0] OFF_SLEEP = 8'h24;

   ////////////////////////////////////////////////////////////////////////
   // per-channel enable field, four bits per channel
   localparam int IE_W = 4;
   localparam int IE_RX = 0;
   localparam int IE_TX = 1;
   localparam int IE_LINE = 2;
   localparam int IE_MODEM = 3;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_LIMIT = 16'h0000;
   localparam logic [31:0] RST_INT_EN = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // source codes
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [2:0] CODE_RX = 3'h1;
   localparam logic [2:0] CODE_RX_TO = 3'h2;
   localparam logic [2:0] CODE_TX = 3'h3;
   localparam logic [2:0] CODE_MODEM = 3'h4;
   localparam logic [2:0] CODE_TIMER = 3'h7;

   // timer commands, low nibble of the command register
   localparam logic [3:0] CMD_INT_ON = 4'h1;
   localparam logic [3:0] CMD_INT_OFF = 4'h2;
   localparam logic [3:0] CMD_ONESHOT = 4'h3;
   localparam logic [3:0] CMD_PERIODIC = 4'h4;
   localparam logic [3:0] CMD_XTAL = 4'h5;
   localparam logic [3:0] CMD_EXT = 4'h6;
   localparam logic [3:0] CMD_START = 4'h9;
   localparam logic [3:0] CMD_STOP = 4'hA;
   localparam logic [3:0] CMD_RESET = 4'hB;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TMR_IDLE = 2'b01,
      TMR_RUN = 2'b10
   } gic_tmr_state_t;

endpackage

// ### design/gic_top.sv
/*
 * gic_top: eight-channel interrupt aggregation (pending flags and 3-bit
 * prioritised source codes) plus a command-driven 16-bit timer, behind an
 * AXI4-Lite slave.
 * Assumes channel engines drive cause levels and event pulses synchronous
 * to aclk, and pulse a read strobe when their status registers are read.
 */
`timescale 1ns/1ps

// Functional notes
// - after reset, pending and all three source-code registers read zero.
// - pending bit n is one while channel n requests service.
// - three source-code registers form 24 bits, one 3-bit highest cause per channel.
// - a pending flag clears only once the host read removes its cause.
// - code zero means no cause or the wake-up indication.
// - code 1 is receive-ready or line error; top priority.
// - code 2 is receive time-out, cleared like receive-ready.
// - code 3 is transmit events, cleared by reading interrupt status.
// - code 4 is modem deltas or Xon/Xoff/special character, with their clears.
// - codes 5 and 6 never appear; code 7 only on channel 0 for timer.
// - channel causes gated by channel enables; timer by its own enable, wake only by the all-asleep state.
// - wake-up interrupt only if all eight channels had been put asleep.
// - timer counts crystal ticks or the external count pin, chosen by command.
// - limit registers read back the programmed value, not the running count.
// - after reset the timer count is zero and the timer disabled.
// - commands self-clear; reading gives 0x01 if timer pending, and clears it.
// - command 0001 enables the timer interrupt, 0010 disables it.
// - command 0011 selects one-shot, 0100 selects re-triggerable.
// - command 0101 selects crystal, 0110 selects external count pin.
// - one-shot times out once, N ticks after start, then idles.
// - re-triggerable times out every N ticks until stopped.
module gic_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // channel cause levels
   input wire logic [7:0] chan_rx_ready,
   input wire logic [7:0] chan_rx_timeout,
   input wire logic [31:0] chan_line_err,
   // channel cause events
   input wire logic [7:0] chan_tx_event,
   input wire logic [7:0] chan_modem_event,
   input wire logic [7:0] chan_xchar_event,
   // channel register read strobes
   input wire logic [7:0] chan_int_status_read,
   input wire logic [7:0] line_status_read,
   input wire logic [7:0] modem_status_read,
   // wake-up and timer clocks
   input wire logic wake_event,
   input wire logic xtal_tick,
   input wire logic external_count_clock_pin,
   // device interrupt and sleep enables
   output logic irq,
   output logic [7:0] sleep_enable
);

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] pending;
      logic [23:0] codes;
      logic [7:0] line_flag;
      logic [7:0] tx_flag;
      logic [7:0] modem_flag;
      logic [7:0] xchar_flag;
      logic wake_flag;
      logic all_asleep;
      logic [31:0] int_en;
      logic [7:0] sleep_en;
      logic [15:0] limit;
      logic [15:0] count;
      gic_pkg::gic_tmr_state_t tmr;
      logic oneshot;
      logic ext_sel;
      logic tmr_int_en;
      logic tmr_pend;
      logic pin_q;
   } gic_state_t;

   gic_state_t st;
   gic_state_t next_st;

   logic do_write;
   logic rd_take;
   logic cmd_read;
   logic tick;
   logic timeout;

   assign awready = !st.aw_got;
   assign wready = !st.w_got;
   assign arready = !st.rvalid;
   assign bvalid = st.bvalid;
   assign bresp = st.bresp;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;
   assign irq = |st.pending;
   assign sleep_enable = st.sleep_en;

   assign do_write = st.aw_got && st.w_got && !st.bvalid;
   assign rd_take = arvalid && !st.rvalid;
   assign cmd_read = rd_take && (araddr == gic_pkg::OFF_CMD);
   // external pin is counted on its rising edge
   assign tick = st.ext_sel ? (external_count_clock_pin && !st.pin_q) : xtal_tick;
   assign timeout = (st.tmr == gic_pkg::TMR_RUN) && tick
                    && (st.count == 16'(st.limit - 16'h0001));

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [2:0] code;
      logic [7:0] req;
      logic rx_c;
      logic to_c;
      logic tx_c;
      logic md_c;
      code = gic_pkg::CODE_NONE;
      req = 8'h00;
      rx_c = 1'b0;
      to_c = 1'b0;
      tx_c = 1'b0;
      md_c = 1'b0;
      next_st = st;
      next_st.pin_q = external_count_clock_pin;

      // write channel capture, either order
      if (awvalid && !st.aw_got) begin
         next_st.aw_got = 1'b1;
         next_st.aw_addr = awaddr;
      end
      if (wvalid && !st.w_got) begin
         next_st.w_got = 1'b1;
         next_st.w_data = wdata;
         next_st.w_strb = wstrb;
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end

      // sticky causes; a set in the clearing cycle wins
      for (int i = 0; i < gic_pkg::NUM_CH; i++) begin
         if (line_status_read[i]) begin
            next_st.line_flag[i] = 1'b0;
         end
         if (|chan_line_err[4*i +: 4]) begin
            next_st.line_flag[i] = 1'b1;
         end
         if (chan_int_status_read[i]) begin
            next_st.tx_flag[i] = 1'b0;
            next_st.xchar_flag[i] = 1'b0;
         end
         if (modem_status_read[i]) begin
            next_st.modem_flag[i] = 1'b0;
         end
         if (chan_tx_event[i]) begin
            next_st.tx_flag[i] = 1'b1;
         end
         if (chan_modem_event[i]) begin
            next_st.modem_flag[i] = 1'b1;
         end
         if (chan_xchar_event[i]) begin
            next_st.xchar_flag[i] = 1'b1;
         end
      end

      // sleep and wake-up indication
      if (chan_int_status_read[0]) begin
         next_st.wake_flag = 1'b0;
      end
      if (&st.sleep_en && st.pending == 8'h00) begin
         next_st.all_asleep = 1'b1;
      end
      if (!(&st.sleep_en)) begin
         next_st.all_asleep = 1'b0;
      end
      if (wake_event && st.all_asleep) begin
         next_st.all_asleep = 1'b0;
         next_st.wake_flag = 1'b1;
      end

      // timer counting
      if (st.tmr == gic_pkg::TMR_RUN && tick) begin
         if (timeout) begin
            next_st.count = 16'h0000;
            if (st.oneshot) begin
               next_st.tmr = gic_pkg::TMR_IDLE;
            end
         end else begin
            next_st.count = 16'(st.count + 16'h0001);
         end
      end
      if (cmd_read) begin
         next_st.tmr_pend = 1'b0;
      end
      if (timeout && st.tmr_int_en) begin
         next_st.tmr_pend = 1'b1;
      end

      // register writes
      if (do_write) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = gic_pkg::RESP_OKAY;
         unique case (st.aw_addr)
            gic_pkg::OFF_PENDING, gic_pkg::OFF_SRC_LOW, gic_pkg::OFF_SRC_MID,
            gic_pkg::OFF_SRC_HIGH, gic_pkg::OFF_RSVD: begin
            end
            gic_pkg::OFF_CMD: begin
               if (st.w_strb[0]) begin
                  unique case (st.w_data[3:0])
                     gic_pkg::CMD_INT_ON: next_st.tmr_int_en = 1'b1;
                     gic_pkg::CMD_INT_OFF: next_st.tmr_int_en = 1'b0;
                     gic_pkg::CMD_ONESHOT: next_st.oneshot = 1'b1;
                     gic_pkg::CMD_PERIODIC: next_st.oneshot = 1'b0;
                     gic_pkg::CMD_XTAL: next_st.ext_sel = 1'b0;
                     gic_pkg::CMD_EXT: next_st.ext_sel = 1'b1;
                     gic_pkg::CMD_START: begin
                        next_st.count = 16'h0000;
                        next_st.tmr = gic_pkg::TMR_RUN;
                     end
                     gic_pkg::CMD_STOP: next_st.tmr = gic_pkg::TMR_IDLE;
                     gic_pkg::CMD_RESET: begin
                        next_st.count = 16'h0000;
                        next_st.tmr = gic_pkg::TMR_IDLE;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            gic_pkg::OFF_LIM_LOW: begin
               if (st.w_strb[0]) begin
                  next_st.limit[7:0] = st.w_data[7:0];
               end
            end
            gic_pkg::OFF_LIM_HIGH: begin
               if (st.w_strb[0]) begin
                  next_st.limit[15:8] = st.w_data[7:0];
               end
            end
            gic_pkg::OFF_INT_EN: begin
               for (int b = 0; b < 4; b++) begin
                  if (st.w_strb[b]) begin
                     next_st.int_en[8*b +: 8] = st.w_data[8*b +: 8];
                  end
               end
            end
            gic_pkg::OFF_SLEEP: begin
               if (st.w_strb[0]) begin
                  next_st.sleep_en = st.w_data[7:0];
               end
            end
            default: next_st.bresp = gic_pkg::RESP_SLVERR;
         endcase
      end

      // register reads
      if (rd_take) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = gic_pkg::RESP_OKAY;
         next_st.rdata = 32'h00000000;
         unique case (araddr)
            gic_pkg::OFF_PENDING: next_st.rdata[7:0] = st.pending;
            gic_pkg::OFF_SRC_LOW: next_st.rdata[7:0] = st.codes[7:0];
            gic_pkg::OFF_SRC_MID: next_st.rdata[7:0] = st.codes[15:8];
            gic_pkg::OFF_SRC_HIGH: next_st.rdata[7:0] = st.codes[23:16];
            gic_pkg::OFF_CMD: next_st.rdata[0] = st.tmr_pend;
            gic_pkg::OFF_RSVD: begin
            end
            gic_pkg::OFF_LIM_LOW: next_st.rdata[7:0] = st.limit[7:0];
            gic_pkg::OFF_LIM_HIGH: next_st.rdata[7:0] = st.limit[15:8];
            gic_pkg::OFF_INT_EN: next_st.rdata = st.int_en;
            gic_pkg::OFF_SLEEP: next_st.rdata[7:0] = st.sleep_en;
            default: next_st.rresp = gic_pkg::RESP_SLVERR;
         endcase
      end

      // prioritised cause per channel; only 0..4 and 7 can be produced
      for (int i = 0; i < gic_pkg::NUM_CH; i++) begin
         rx_c = st.int_en[gic_pkg::IE_W*i + gic_pkg::IE_RX] && chan_rx_ready[i]
                || st.int_en[gic_pkg::IE_W*i + gic_pkg::IE_LINE] && st.line_flag[i];
         to_c = st.int_en[gic_pkg::IE_W*i + gic_pkg::IE_RX] && chan_rx_timeout[i];
         tx_c = st.int_en[gic_pkg::IE_W*i + gic_pkg::IE_TX] && st.tx_flag[i];
         md_c = st.int_en[gic_pkg::IE_W*i + gic_pkg::IE_MODEM]
                && (st.modem_flag[i] || st.xchar_flag[i]);
         if (rx_c) begin
            code = gic_pkg::CODE_RX;
         end else if (to_c) begin
            code = gic_pkg::CODE_RX_TO;
         end else if (tx_c) begin
            code = gic_pkg::CODE_TX;
         end else if (md_c) begin
            code = gic_pkg::CODE_MODEM;
         end else if (i == 0 && st.tmr_pend) begin
            code = gic_pkg::CODE_TIMER;
         end else begin
            code = gic_pkg::CODE_NONE;
         end
         next_st.codes[3*i +: 3] = code;
         req[i] = rx_c || to_c || tx_c || md_c
                  || (i == 0 && (st.tmr_pend || st.wake_flag));
      end
      next_st.pending = req;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.pending <= gic_pkg::RST_BYTE;
         st.codes <= {3{gic_pkg::RST_BYTE}};
         st.int_en <= gic_pkg::RST_INT_EN;
         st.sleep_en <= gic_pkg::RST_BYTE;
         st.limit <= gic_pkg::RST_LIMIT;
         st.count <= gic_pkg::RST_LIMIT;
         st.tmr <= gic_pkg::TMR_IDLE;
         st.rdata <= 32'h00000000;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   function automatic logic bad_codes(input logic [23:0] c);
      logic bad;
      bad = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (c[3*i +: 3] == 3'h5 || c[3*i +: 3] == 3'h6) begin
            bad = 1'b1;
         end
         if (i != 0 && c[3*i +: 3] == 3'h7) begin
            bad = 1'b1;
         end
      end
      return bad;
   endfunction

   a_reset_clean: assert property ($rose(aresetn) |-> st.pending == 8'h00
      && st.codes == 24'h0 && st.tmr == gic_pkg::TMR_IDLE)
      else $error("state not clear after reset");
   a_code_legal: assert property (!bad_codes(st.codes))
      else $error("illegal source code reported");
   a_irq_pending: assert property ((st.codes[2:0] != 3'h0) |-> irq && st.pending[0])
      else $error("code shown without pending flag");
   a_rx_top_prio: assert property (chan_rx_ready[3] && st.int_en[12]
      |=> st.codes[11:9] == 3'h1)
      else $error("receive cause not top priority");
   a_tx_clear: assert property (chan_int_status_read[2] && !chan_tx_event[2]
      |=> !st.tx_flag[2])
      else $error("transmit cause not cleared by status read");
   a_cmd_readback: assert property (cmd_read
      |=> rvalid && rdata == {31'h0, $past(st.tmr_pend)})
      else $error("command register read value wrong");
   a_cmd_read_clr: assert property (cmd_read && !timeout |=> !st.tmr_pend)
      else $error("timer pending not cleared by read");
   a_oneshot_stop: assert property (timeout && st.oneshot
      |=> st.tmr == gic_pkg::TMR_IDLE && st.count == 16'h0)
      else $error("one-shot timer kept running");
   a_periodic_run: assert property (timeout && !st.oneshot
      |=> st.tmr == gic_pkg::TMR_RUN && st.count == 16'h0)
      else $error("periodic timer did not reload");
   a_limit_read: assert property (rd_take && araddr == gic_pkg::OFF_LIM_LOW
      |=> rdata == {24'h0, $past(st.limit[7:0])})
      else $error("limit readback wrong");
   a_wake_gate: assert property (wake_event && !st.all_asleep && !st.wake_flag
      && !chan_int_status_read[0] |=> !st.wake_flag)
      else $error("wake flag without full sleep");

   c_timeout: cover property (timeout && st.tmr_int_en);
   c_cmd_read_pend: cover property (cmd_read && st.tmr_pend);
   c_wake: cover property (wake_event && st.all_asleep);
   c_write_done: cover property (st.bvalid && bready);

endmodule

// ### tb/gic_tick_model.sv
/*
 gic_tick_model: the count clock sources that sit outside the block.
 Assumes the bench raises ext_run only while it wants the pin to toggle.
*/
`timescale 1ns/1ps
module gic_tick_model #(
   parameter int TICK_DIV = 2
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic ext_run,
   // count clocks
   output logic xtal_tick,
   output logic ext_pin
);
   int div;
   logic [1:0] ph;
   // fixed tick spacing keeps timer periods exactly predictable
   always @(posedge aclk) begin
      if (!aresetn) begin
         div <= 0;
         ph <= 2'h0;
         xtal_tick <= 1'b0;
         ext_pin <= 1'b0;
      end else begin
         div <= (div == TICK_DIV - 1) ? 0 : div + 1;
         xtal_tick <= (div == TICK_DIV - 1);
         ph <= ext_run ? ph + 2'h1 : 2'h0;
         // pin stands still low when not in use
         ext_pin <= ext_run & ph[1];
      end
   end
endmodule

// ### tb/global_irq_and_gp_timer_tb.sv
/*
 global_irq_and_gp_timer_tb: register-level tests over AXI4-Lite.
 Assumes one crystal tick every two aclk cycles from gic_tick_model.
*/
`timescale 1ns/1ps
module global_irq_and_gp_timer_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, ch_err = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, irq, xtal_tick, ext_pin;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, data;
   logic [7:0] sleep_enable;
   logic [7:0] ch_rdy = 8'h00, ch_to = 8'h00, tx_ev = 8'h00, md_ev = 8'h00, xc_ev = 8'h00;
   logic [7:0] isr_rd = 8'h00, lsr_rd = 8'h00, msr_rd = 8'h00;
   logic wake = 1'b0, ext_run = 1'b0;
   int fails = 0, tests_run = 0;
   time t1;

   always #4 aclk = ~aclk;

   gic_tick_model gic_tick_model_i (.aclk(aclk), .aresetn(aresetn), .ext_run(ext_run),
      .xtal_tick(xtal_tick), .ext_pin(ext_pin));

   gic_top gic_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .chan_rx_ready(ch_rdy), .chan_rx_timeout(ch_to),
      .chan_line_err(ch_err), .chan_tx_event(tx_ev), .chan_modem_event(md_ev),
      .chan_xchar_event(xc_ev), .chan_int_status_read(isr_rd), .line_status_read(lsr_rd),
      .modem_status_read(msr_rd), .wake_event(wake), .xtal_tick(xtal_tick),
      .external_count_clock_pin(ext_pin), .irq(irq), .sleep_enable(sleep_enable));

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      fails++;
      summarize();
   endtask

   // handshakes judged at the rising edge that moves them, released on that edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic hb;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      hb = 1'b0;
      for (int n = 0; n < 50 && !hb; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         hb = bvalid && bready;
         resp = bresp;
         if (hb) bready <= 1'b0;
      end
      if (!hb) hang();
   endtask

   task automatic rd(input logic [7:0] a);
      logic hr;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      hr = 1'b0;
      for (int n = 0; n < 50 && !hr; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         hr = rvalid && rready;
         data = rdata;
         resp = rresp;
         if (hr) rready <= 1'b0;
      end
      if (!hr) hang();
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(data, exp);
   endtask

   task automatic cmd(input logic [3:0] x);
      wr(gic_pkg::OFF_CMD, {28'h0000000, x});
   endtask

   task automatic wait_irq(input logic lvl);
      int c;
      c = 0;
      while (irq !== lvl && c < 500) begin
         @(negedge aclk);
         c++;
      end
      if (c == 500) hang();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) begin
         rc(a[7:0], 32'h00000000);
      end
      chk(irq, 1'b0);
      wr(8'h40, 32'h00000001);
      chk(resp, gic_pkg::RESP_SLVERR);
      rd(8'h40);
      chk(resp, gic_pkg::RESP_SLVERR);
      wr(gic_pkg::OFF_LIM_HIGH, 32'h000000AB);
      rc(gic_pkg::OFF_LIM_HIGH, 32'h000000AB);
      wr(gic_pkg::OFF_LIM_HIGH, 32'h00000000);
      wr(gic_pkg::OFF_INT_EN, 32'h80001240);
      // ch3 enabled, ch5 left masked
      @(posedge aclk);
      ch_rdy <= 8'h28;
      ch_to <= 8'h08;
      rc(gic_pkg::OFF_PENDING, 32'h00000008);
      rc(gic_pkg::OFF_SRC_MID, 32'h00000002);
      ch_rdy <= 8'h00;
      rc(gic_pkg::OFF_SRC_MID, 32'h00000004);
      ch_to <= 8'h00;
      rc(gic_pkg::OFF_PENDING, 32'h00000000);
      @(posedge aclk);
      tx_ev <= 8'h04;
      @(posedge aclk);
      tx_ev <= 8'h00;
      rc(gic_pkg::OFF_SRC_LOW, 32'h000000C0);
      chk(irq, 1'b1);
      isr_rd <= 8'h04;
      @(posedge aclk);
      isr_rd <= 8'h00;
      rc(gic_pkg::OFF_PENDING, 32'h00000000);
      md_ev <= 8'h80;
      @(posedge aclk);
      md_ev <= 8'h00;
      rc(gic_pkg::OFF_SRC_HIGH, 32'h00000080);
      msr_rd <= 8'h80;
      @(posedge aclk);
      msr_rd <= 8'h00;
      rc(gic_pkg::OFF_SRC_HIGH, 32'h00000000);
      xc_ev <= 8'h80;
      @(posedge aclk);
      xc_ev <= 8'h00;
      rc(gic_pkg::OFF_SRC_HIGH, 32'h00000080);
      isr_rd <= 8'h80;
      @(posedge aclk);
      isr_rd <= 8'h00;
      rc(gic_pkg::OFF_SRC_HIGH, 32'h00000000);
      ch_err <= 32'h00000020;
      @(posedge aclk);
      ch_err <= 32'h00000000;
      rc(gic_pkg::OFF_SRC_LOW, 32'h00000008);
      lsr_rd <= 8'h02;
      @(posedge aclk);
      lsr_rd <= 8'h00;
      rc(gic_pkg::OFF_PENDING, 32'h00000000);
      wr(gic_pkg::OFF_SLEEP, 32'h000000FF);
      chk(sleep_enable, 32'h000000FF);
      wake <= 1'b1;
      @(posedge aclk);
      wake <= 1'b0;
      rc(gic_pkg::OFF_PENDING, 32'h00000001);
      rc(gic_pkg::OFF_SRC_LOW, 32'h00000000);
      isr_rd <= 8'h01;
      @(posedge aclk);
      isr_rd <= 8'h00;
      wr(gic_pkg::OFF_SLEEP, 32'h00000000);
      chk(sleep_enable, 32'h00000000);
      wake <= 1'b1;
      @(posedge aclk);
      wake <= 1'b0;
      rc(gic_pkg::OFF_PENDING, 32'h00000000);
      // one-shot on crystal ticks, then on the external count pin, limit within the legal range
      wr(gic_pkg::OFF_LIM_LOW, 32'h00000005);
      cmd(gic_pkg::CMD_INT_ON);
      cmd(gic_pkg::CMD_ONESHOT);
      cmd(gic_pkg::CMD_XTAL);
      cmd(gic_pkg::CMD_START);
      wait_irq(1'b1);
      rc(gic_pkg::OFF_SRC_LOW, 32'h00000007);
      rc(gic_pkg::OFF_CMD, 32'h00000001);
      rc(gic_pkg::OFF_CMD, 32'h00000000);
      repeat (60) @(negedge aclk);
      chk(irq, 1'b0);
      cmd(gic_pkg::CMD_EXT);
      cmd(gic_pkg::CMD_START);
      repeat (40) @(negedge aclk);
      chk(irq, 1'b0);
      @(posedge aclk);
      ext_run <= 1'b1;
      wait_irq(1'b1);
      rc(gic_pkg::OFF_CMD, 32'h00000001);
      ext_run <= 1'b0;
      cmd(gic_pkg::CMD_XTAL);
      cmd(gic_pkg::CMD_INT_OFF);
      cmd(gic_pkg::CMD_START);
      repeat (40) @(negedge aclk);
      rc(gic_pkg::OFF_CMD, 32'h00000000);
      // periodic: spacing of two rises is N ticks of two cycles each
      wr(gic_pkg::OFF_LIM_LOW, 32'h00000014);
      cmd(gic_pkg::CMD_INT_ON);
      cmd(gic_pkg::CMD_PERIODIC);
      cmd(gic_pkg::CMD_START);
      wait_irq(1'b1);
      t1 = $time;
      rc(gic_pkg::OFF_CMD, 32'h00000001);
      rc(gic_pkg::OFF_LIM_LOW, 32'h00000014);
      wait_irq(1'b0);
      wait_irq(1'b1);
      chk(32'(($time - t1) / 8), 32'h00000028);
      cmd(gic_pkg::CMD_STOP);
      rd(gic_pkg::OFF_CMD);
      repeat (100) @(negedge aclk);
      chk(irq, 1'b0);
      // reset command stops a running timer; a reserved code must not restart it
      cmd(gic_pkg::CMD_START);
      cmd(gic_pkg::CMD_RESET);
      cmd(4'hC);
      repeat (100) @(negedge aclk);
      chk(irq, 1'b0);
      // reset in mid-run while the timer counts
      cmd(gic_pkg::CMD_START);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(gic_pkg::OFF_LIM_LOW, 32'h00000000);
      rc(gic_pkg::OFF_PENDING, 32'h00000000);
      repeat (100) @(negedge aclk);
      chk(irq, 1'b0);
      summarize();
   end
endmodule
